// >>> hdl/msta_arbiter.v
// mission state trigger arbiter with per-state masks
`include "msta_defines.vh"
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [R1] Triggers 0, 1 and 2 send every state to safe recovery and are never masked.
// [R2] Those three act at once, ahead of and apart from ordinary triggers.
// [R3] In active, trigger 4 or 5 warm-resets all rails and returns to active.
// [R4] In mcu-only, trigger 7 or 8 warm-resets all rails and returns to mcu-only.
// [R5] With both sleep signals high, trigger 14 moves mcu-only or s2r to active.
// [R6] With pattern 10, trigger 17 moves active or s2r to mcu-only.
// [R7] With the mcu sleep signal low, trigger 18 moves active or mcu-only to s2r.
// [R8] Software bit 0 raises trigger 19 to standby and clears itself when used.
// [R9] Each mission state applies its 28-bit mask, a set bit disabling it.
// [R10] On and off requests are formed from pins combined with register bits.
// [R11] Among active unmasked triggers the lowest id wins, after dropping those whose target is the present state.
// [R12] Entering a state loads that state's mask.
// [R13] Each sleep signal is the OR of its pin and its software bit.
// [R14] Software off goes to standby, or low-power standby when select is set.
// [R15] Unused ids 6 and 21 to 27 are held inactive and always masked.
// [R16] One evaluation per clock, at most one transition per evaluation.
module msta_arbiter #(
  parameter NTRIG = `MSTA_NTRIG
) (
  input  wire                   clock,
  input  wire                   rst_n,
  input  wire                   imm_shutdown_fault,
  input  wire                   mcu_power_fault,
  input  wire                   orderly_shutdown_fault,
  input  wire                   watchdog_fault,
  input  wire                   mcu_error_monitor_fault,
  input  wire                   soc_power_fault,
  input  wire                   on_request_pin,
  input  wire                   on_request_en,
  input  wire [1:0]             startup_dest,
  input  wire                   force_standby,
  input  wire                   wake_input_one,
  input  wire                   wake_input_two,
  input  wire                   soc_sleep_pin,
  input  wire                   mcu_sleep_pin,
  input  wire                   recovery_done,
  input  wire                   warm_reset_done,
  input  wire [7:0]             reg_addr,
  input  wire [7:0]             reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [7:0]             reg_rdata,
  output reg  [6:0]             state_out,
  output reg  [NTRIG-1:0]       state_trigger_mask,
  output reg                    warm_reset_req,
  output reg                    self_check_start,
  output reg                    crc_enable,
  output reg                    trig_taken,
  output reg  [`MSTA_IDW-1:0]   trig_id
);
  localparam [7:0] A_CTRL   = 8'h00;
  localparam [7:0] A_SWTRIG = 8'h01;
  localparam [7:0] A_STATE  = 8'h02;
  localparam [7:0] A_LASTID = 8'h03;
  localparam ST_STANDBY = `MSTA_ST_STANDBY;
  localparam ST_ACTIVE  = `MSTA_ST_ACTIVE;
  localparam ST_MCU     = `MSTA_ST_MCU;
  localparam ST_S2R     = `MSTA_ST_S2R;
  localparam ST_SAFE    = `MSTA_ST_SAFE;
  localparam ST_LPSTBY  = `MSTA_ST_LPSTBY;
  localparam ST_WARM    = `MSTA_ST_WARM;

  // ctrl: [0] soc sleep sw bit, [1] mcu sleep sw bit, [2] low_power_standby select
  reg              soc_sleep_sw_bit_reg;
  reg              mcu_sleep_sw_bit_reg;
  reg              low_power_standby_select_reg;
  reg  [2:0]       sw_trig_reg;
  reg  [6:0]       state_reg;
  reg  [6:0]       state_next;
  reg  [6:0]       warm_ret_reg;
  reg  [6:0]       warm_ret_next;
  reg  [NTRIG-1:0] mask_next;
  reg  [NTRIG-1:0] trig_vec;
  reg  [NTRIG-1:0] stay_vec;
  reg              soc_sleep_ctrl;
  reg              mcu_sleep_ctrl;
  reg              on_request;
  wire [NTRIG-1:0] imm_req;
  wire [NTRIG-1:0] ord_req;
  wire             imm_hit;
  wire             ord_hit;
  wire [`MSTA_IDW-1:0] imm_idx;
  wire [`MSTA_IDW-1:0] ord_idx;
  wire             win_hit;
  wire [`MSTA_IDW-1:0] win_idx;
  wire             sw_write;

  always @* begin
    soc_sleep_ctrl = soc_sleep_pin | soc_sleep_sw_bit_reg; // [R13]
    mcu_sleep_ctrl = mcu_sleep_pin | mcu_sleep_sw_bit_reg; // [R13]
    on_request     = on_request_pin & on_request_en; // [R10]
    trig_vec = {NTRIG{1'b0}}; // [R15]
    trig_vec[`MSTA_T_IMM_SD]   = imm_shutdown_fault;
    trig_vec[`MSTA_T_MCU_PWR]  = mcu_power_fault;
    trig_vec[`MSTA_T_ORD_SD]   = orderly_shutdown_fault;
    trig_vec[`MSTA_T_FORCE_SB] = force_standby;
    trig_vec[`MSTA_T_WD_ACT]   = watchdog_fault;
    trig_vec[`MSTA_T_ESM_ACT]  = mcu_error_monitor_fault;
    trig_vec[`MSTA_T_WD_MCU]   = watchdog_fault;
    trig_vec[`MSTA_T_ESM_MCU]  = mcu_error_monitor_fault;
    trig_vec[`MSTA_T_SOC_PWR]  = soc_power_fault;
    trig_vec[`MSTA_T_SW1]      = sw_trig_reg[1];
    trig_vec[`MSTA_T_SW2]      = sw_trig_reg[2];
    trig_vec[`MSTA_T_SU_ACT]   = on_request & (startup_dest == 2'h3); // [R10]
    trig_vec[`MSTA_T_WAKE1]    = wake_input_one;
    trig_vec[`MSTA_T_SLP_A]    = mcu_sleep_ctrl & soc_sleep_ctrl; // [R5]
    trig_vec[`MSTA_T_SU_MCU]   = on_request & (startup_dest == 2'h2); // [R10]
    trig_vec[`MSTA_T_WAKE2]    = wake_input_two;
    trig_vec[`MSTA_T_SLP_B]    = mcu_sleep_ctrl & ~soc_sleep_ctrl; // [R6]
    trig_vec[`MSTA_T_SLP_CD]   = ~mcu_sleep_ctrl; // [R7]
    trig_vec[`MSTA_T_SW0]      = sw_trig_reg[0]; // [R8]
    trig_vec[`MSTA_T_ALWAYS]   = 1'b1;
  end

  // a trigger whose target is the present state is dropped: a level held
  // request would otherwise win forever and starve every higher id
  always @* begin
    stay_vec = {NTRIG{1'b0}};
    case (state_reg)
      ST_ACTIVE: begin
        stay_vec[`MSTA_T_SU_ACT] = 1'b1;
        stay_vec[`MSTA_T_WAKE1]  = 1'b1;
        stay_vec[`MSTA_T_SLP_A]  = 1'b1;
      end
      ST_MCU: begin
        stay_vec[`MSTA_T_SOC_PWR] = 1'b1;
        stay_vec[`MSTA_T_SU_MCU]  = 1'b1;
        stay_vec[`MSTA_T_WAKE2]   = 1'b1;
        stay_vec[`MSTA_T_SLP_B]   = 1'b1;
      end
      ST_S2R: begin
        stay_vec[`MSTA_T_SLP_CD] = 1'b1;
      end
      default: begin
        stay_vec = {NTRIG{1'b0}};
      end
    endcase
  end

  // the immediate group bypasses the mask so no state can block it
  assign imm_req = trig_vec & `MSTA_IMM_BITS; // [R1] [R2]
  assign ord_req = trig_vec & ~state_trigger_mask & ~stay_vec &
                   ~`MSTA_IMM_BITS; // [R9] [R8] [R11]

  msta_prio_enc #(
    .N  (NTRIG),
    .IW (`MSTA_IDW)
  ) u_imm_enc (
    .req (imm_req),
    .hit (imm_hit),
    .idx (imm_idx)
  );

  msta_prio_enc #(
    .N  (NTRIG),
    .IW (`MSTA_IDW)
  ) u_ord_enc (
    .req (ord_req),
    .hit (ord_hit),
    .idx (ord_idx)
  );

  // during warm reset and safe recovery only immediate triggers count
  assign win_hit = imm_hit |
                   (ord_hit & (state_reg != ST_WARM) & (state_reg != ST_SAFE));
  assign win_idx = imm_hit ? imm_idx : ord_idx; // [R2] [R11]
  assign sw_write = reg_wr & (reg_addr == A_SWTRIG);

  function [NTRIG-1:0] mask_of;
    input [6:0] st;
    begin
      case (st)
        ST_STANDBY: mask_of = `MSTA_MASK_STANDBY;
        ST_ACTIVE:  mask_of = `MSTA_MASK_ACTIVE;
        ST_MCU:     mask_of = `MSTA_MASK_MCU;
        ST_S2R:     mask_of = `MSTA_MASK_S2R;
        ST_LPSTBY:  mask_of = `MSTA_MASK_LPSTBY;
        default:    mask_of = `MSTA_MASK_SAFE;
      endcase
    end
  endfunction

  always @* begin
    state_next    = state_reg;
    warm_ret_next = warm_ret_reg;
    if (state_reg == ST_WARM && !imm_hit) begin
      if (warm_reset_done) begin
        state_next = warm_ret_reg; // [R3] [R4]
      end
    end else if (state_reg == ST_SAFE && !imm_hit) begin
      if (recovery_done) begin
        state_next = ST_STANDBY;
      end
    end else if (win_hit) begin // [R16]
      case (win_idx)
        `MSTA_T_IMM_SD, `MSTA_T_MCU_PWR, `MSTA_T_ORD_SD,
        `MSTA_T_ALWAYS:
          state_next = ST_SAFE; // [R1]
        `MSTA_T_FORCE_SB, `MSTA_T_SW0:
          state_next = low_power_standby_select_reg ?
                       ST_LPSTBY : ST_STANDBY; // [R8] [R14]
        `MSTA_T_WD_ACT, `MSTA_T_ESM_ACT: begin
          state_next    = ST_WARM; // [R3]
          warm_ret_next = ST_ACTIVE;
        end
        `MSTA_T_WD_MCU, `MSTA_T_ESM_MCU: begin
          state_next    = ST_WARM; // [R4]
          warm_ret_next = ST_MCU;
        end
        `MSTA_T_SOC_PWR, `MSTA_T_SU_MCU, `MSTA_T_WAKE2, `MSTA_T_SLP_B:
          state_next = ST_MCU; // [R6]
        `MSTA_T_SU_ACT, `MSTA_T_WAKE1, `MSTA_T_SLP_A:
          state_next = ST_ACTIVE; // [R5]
        `MSTA_T_SLP_CD:
          state_next = ST_S2R; // [R7]
        default:
          state_next = state_reg;
      endcase
    end
    mask_next = mask_of(state_next); // [R12]
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      state_reg          <= ST_STANDBY;
      warm_ret_reg       <= ST_ACTIVE;
      state_out          <= ST_STANDBY;
      state_trigger_mask <= `MSTA_MASK_STANDBY;
      warm_reset_req     <= 1'b0;
      self_check_start   <= 1'b0;
      crc_enable         <= 1'b0;
      trig_taken         <= 1'b0;
      trig_id            <= `MSTA_NO_ID;
    end else begin
      state_reg          <= state_next;
      warm_ret_reg       <= warm_ret_next;
      state_out          <= state_next;
      state_trigger_mask <= mask_next; // [R12]
      warm_reset_req     <= (state_next == ST_WARM);
      self_check_start   <= win_hit & (win_idx == `MSTA_T_SW1);
      if (win_hit && win_idx == `MSTA_T_SW2) begin
        crc_enable <= 1'b1;
      end
      trig_taken <= win_hit & (state_next != state_reg |
                    win_idx == `MSTA_T_SW1 | win_idx == `MSTA_T_SW2);
      if (win_hit) begin
        trig_id <= win_idx;
      end
    end
  end

  // software trigger bits: a write sets, use clears; write wins so none lost
  always @(posedge clock) begin
    if (!rst_n) begin
      sw_trig_reg <= 3'h0;
    end else begin
      sw_trig_reg[0] <= (sw_write & reg_wdata[0]) |
                        (sw_trig_reg[0] &
                         ~(win_hit & win_idx == `MSTA_T_SW0)); // [R8]
      sw_trig_reg[1] <= (sw_write & reg_wdata[1]) |
                        (sw_trig_reg[1] & ~(win_hit & win_idx == `MSTA_T_SW1));
      sw_trig_reg[2] <= (sw_write & reg_wdata[2]) |
                        (sw_trig_reg[2] & ~(win_hit & win_idx == `MSTA_T_SW2));
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      soc_sleep_sw_bit_reg         <= 1'b0;
      mcu_sleep_sw_bit_reg         <= 1'b0;
      low_power_standby_select_reg <= 1'b0;
      reg_rdata                    <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == A_CTRL) begin
        soc_sleep_sw_bit_reg         <= reg_wdata[0];
        mcu_sleep_sw_bit_reg         <= reg_wdata[1];
        low_power_standby_select_reg <= reg_wdata[2];
      end
      // unmapped reads answer zero; data valid only the cycle after a read
      if (!reg_rd) begin
        reg_rdata <= 8'h00;
      end else if (reg_addr == A_CTRL) begin
        reg_rdata <= {5'h00, low_power_standby_select_reg,
                      mcu_sleep_sw_bit_reg, soc_sleep_sw_bit_reg};
      end else if (reg_addr == A_SWTRIG) begin
        reg_rdata <= {5'h00, sw_trig_reg};
      end else if (reg_addr == A_STATE) begin
        reg_rdata <= {1'b0, state_reg};
      end else if (reg_addr == A_LASTID) begin
        reg_rdata <= {3'h0, trig_id};
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end
endmodule // msta_arbiter
`default_nettype wire

// >>> hdl/msta_defines.vh
// constants for the mission state trigger arbiter
`ifndef MSTA_DEFINES_VH
`define MSTA_DEFINES_VH
`define MSTA_NTRIG        28
`define MSTA_MASK_STANDBY 28'hFFE4FF8
`define MSTA_MASK_ACTIVE  28'hFF181C0
`define MSTA_MASK_MCU     28'hFF01270
`define MSTA_MASK_S2R     28'hFFC9FF0
`define MSTA_MASK_SAFE    28'hFFFFFF8
`define MSTA_MASK_LPSTBY  28'hFFE4FF8
`define MSTA_ST_STANDBY   7'h01
`define MSTA_ST_ACTIVE    7'h02
`define MSTA_ST_MCU       7'h04
`define MSTA_ST_S2R       7'h08
`define MSTA_ST_SAFE      7'h10
`define MSTA_ST_LPSTBY    7'h20
`define MSTA_ST_WARM      7'h40
`define MSTA_T_IMM_SD     0
`define MSTA_T_MCU_PWR    1
`define MSTA_T_ORD_SD     2
`define MSTA_T_FORCE_SB   3
`define MSTA_T_WD_ACT     4
`define MSTA_T_ESM_ACT    5
`define MSTA_T_WD_MCU     7
`define MSTA_T_ESM_MCU    8
`define MSTA_T_SOC_PWR    9
`define MSTA_T_SW1        10
`define MSTA_T_SW2        11
`define MSTA_T_SU_ACT     12
`define MSTA_T_WAKE1      13
`define MSTA_T_SLP_A      14
`define MSTA_T_SU_MCU     15
`define MSTA_T_WAKE2      16
`define MSTA_T_SLP_B      17
`define MSTA_T_SLP_CD     18
`define MSTA_T_SW0        19
`define MSTA_T_ALWAYS     20
`define MSTA_IDW          5
`define MSTA_NO_ID        5'h1F
`define MSTA_IMM_BITS     28'h0000007
`endif

// >>> hdl/msta_prio_enc.v
// lowest-index priority encoder
`timescale 1ns/1ps
`default_nettype none
module msta_prio_enc #(
  parameter N  = 28,
  parameter IW = 5
) (
  input  wire [N-1:0]  req,
  output reg           hit,
  output reg  [IW-1:0] idx
);
  integer i;
  always @* begin
    hit = 1'b0;
    idx = {IW{1'b1}};
    // scan downward so the lowest id lands last and wins
    for (i = N-1; i >= 0; i = i - 1) begin
      if (req[i]) begin
        hit = 1'b1;
        idx = i[IW-1:0];
      end
    end
  end
endmodule // msta_prio_enc
`default_nettype wire

// >>> verification/msta_arbiter_assertions.sv
// port-level checks for the trigger arbiter
`include "msta_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module msta_arbiter_assertions #(parameter NTRIG = `MSTA_NTRIG) (
  input wire logic             clock,
  input wire logic             rst_n,
  input wire logic             imm_shutdown_fault,
  input wire logic             mcu_power_fault,
  input wire logic             orderly_shutdown_fault,
  input wire logic             watchdog_fault,
  input wire logic             mcu_error_monitor_fault,
  input wire logic             force_standby,
  input wire logic             warm_reset_done,
  input wire logic [7:0]       reg_addr,
  input wire logic             reg_rd,
  input wire logic [7:0]       reg_rdata,
  input wire logic [6:0]       state_out,
  input wire logic [NTRIG-1:0] state_trigger_mask,
  input wire logic             warm_reset_req,
  input wire logic             trig_taken,
  input wire logic [4:0]       trig_id
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic             imm;
  logic             nrm;
  logic [6:0]       last_st;
  logic [NTRIG-1:0] exp_mask;
  assign imm = imm_shutdown_fault | mcu_power_fault | orderly_shutdown_fault;
  assign nrm = !imm && !force_standby;
  // warm exit must land back where it left from
  always_ff @(posedge clock)
    if (!rst_n)
      last_st <= `MSTA_ST_STANDBY;
    else if (state_out != `MSTA_ST_WARM)
      last_st <= state_out;
  always_comb
    case (state_out)
      `MSTA_ST_ACTIVE: exp_mask = `MSTA_MASK_ACTIVE;
      `MSTA_ST_MCU:    exp_mask = `MSTA_MASK_MCU;
      `MSTA_ST_S2R:    exp_mask = `MSTA_MASK_S2R;
      `MSTA_ST_STANDBY,
      `MSTA_ST_LPSTBY: exp_mask = `MSTA_MASK_STANDBY;
      default:         exp_mask = `MSTA_MASK_SAFE;
    endcase
  sequence s_warm_exit;
    state_out == `MSTA_ST_WARM && warm_reset_done && !imm;
  endsequence
  a_imm_to_safe: assert property (
    imm |=> state_out == `MSTA_ST_SAFE)
    else $error("shutdown fault missed safe state");
  a_low_id_wins: assert property (
    mcu_power_fault && !imm_shutdown_fault |=> trig_id == 5'h01)
    else $error("wrong winning id");
  a_act_warm: assert property (
    state_out == `MSTA_ST_ACTIVE && watchdog_fault && nrm
    |=> state_out == `MSTA_ST_WARM && warm_reset_req && trig_id == 5'h04)
    else $error("active watchdog missed warm reset");
  a_mcu_warm: assert property (
    state_out == `MSTA_ST_MCU && !watchdog_fault && mcu_error_monitor_fault
    && nrm |=> state_out == `MSTA_ST_WARM && trig_id == 5'h08)
    else $error("mcu monitor fault missed warm reset");
  a_warm_return: assert property (
    s_warm_exit |=> state_out == last_st)
    else $error("warm reset returned to wrong state");
  a_mask_state: assert property (
    state_trigger_mask == exp_mask)
    else $error("mask does not match state");
  a_one_move: assert property (
    $past(rst_n) && $changed(state_out) && !($past(state_out) & 7'h50)
    |-> trig_taken)
    else $error("state moved without a taken trigger");
  a_rd_zero: assert property (!reg_rd || reg_addr > 8'h03 |=> reg_rdata == 8'h00)
    else $error("read data not zero");
endmodule // msta_arbiter_assertions
bind msta_arbiter msta_arbiter_assertions #(.NTRIG(NTRIG)) u_chk (
  .clock(clock), .rst_n(rst_n), .imm_shutdown_fault(imm_shutdown_fault),
  .mcu_power_fault(mcu_power_fault), .watchdog_fault(watchdog_fault),
  .orderly_shutdown_fault(orderly_shutdown_fault), .trig_id(trig_id),
  .mcu_error_monitor_fault(mcu_error_monitor_fault), .reg_rd(reg_rd),
  .force_standby(force_standby), .warm_reset_done(warm_reset_done),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .state_out(state_out),
  .state_trigger_mask(state_trigger_mask), .warm_reset_req(warm_reset_req),
  .trig_taken(trig_taken));
`default_nettype wire

// >>> verification/msta_host_model.sv
// host model: sleep pins and register port
`timescale 1ns/1ps
`default_nettype none
module msta_host_model (
  input  wire logic       clock,
  input  wire logic [7:0] reg_rdata,
  output logic            soc_sleep_pin,
  output logic            mcu_sleep_pin,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  initial begin
    {soc_sleep_pin, mcu_sleep_pin, reg_wr, reg_rd} = 4'h0;
    {reg_addr, reg_wdata} = 16'h0000;
  end
  // pin and software bit are both ours to drive
  task sleep(input logic soc, input logic mcu);
    @(posedge clock) soc_sleep_pin <= soc;
    mcu_sleep_pin <= mcu;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock) reg_wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock) reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule // msta_host_model
`default_nettype wire

// >>> verification/msta_arbiter_test.sv
// self-checking bench for the trigger arbiter
`include "msta_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module msta_arbiter_test;
  logic       clock = 1'b0, rst_n = 1'b0, wd = 1'b0, esm = 1'b0;
  logic       on_pin = 1'b0, on_en = 1'b0, rec_done = 1'b0, wrm_done = 1'b0;
  logic [1:0] dest = 2'h3;
  logic [2:0] flt = 3'h0;
  logic [7:0] rdat;
  wire        soc_pin, mcu_pin, wr, rd, wrq, tk, scs, crc;
  wire  [7:0] addr, wdata, rdata;
  wire  [6:0] st;
  wire [27:0] msk;
  wire  [4:0] tid;
  int         err_total = 0;
  int         comparisons = 0;
  always #5 clock = ~clock;
  msta_arbiter u_dut (
    .clock(clock), .rst_n(rst_n),
    .imm_shutdown_fault(flt[0]), .mcu_power_fault(flt[1]),
    .orderly_shutdown_fault(flt[2]), .watchdog_fault(wd),
    .mcu_error_monitor_fault(esm), .soc_power_fault(1'b0),
    .on_request_pin(on_pin), .on_request_en(on_en), .startup_dest(dest),
    .force_standby(1'b0), .wake_input_one(1'b0), .wake_input_two(1'b0),
    .soc_sleep_pin(soc_pin), .mcu_sleep_pin(mcu_pin),
    .recovery_done(rec_done), .warm_reset_done(wrm_done),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .state_out(st), .state_trigger_mask(msk),
    .warm_reset_req(wrq), .self_check_start(scs), .crc_enable(crc),
    .trig_taken(tk), .trig_id(tid));
  msta_host_model u_host (.clock(clock), .reg_rdata(rdata), .reg_addr(addr),
    .soc_sleep_pin(soc_pin), .mcu_sleep_pin(mcu_pin), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task see(input logic [6:0] e);
    @(posedge clock);
    #1 chk(st, e);
  endtask
  task give_verdict;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // stacked faults: lowest id must win
  task t_shutdown;
    for (int i = 0; i < 3; i++) begin
      @(posedge clock) flt <= 3'h7 << i;
      see(`MSTA_ST_SAFE);
      chk(tid, i);
      chk(tk, 1'b1);
      @(posedge clock) flt <= 3'h0;
      rec_done <= 1'b1;
      @(posedge clock) rec_done <= 1'b0;
    end
  endtask
  task t_start;
    u_host.sleep(1'b1, 1'b1);
    @(posedge clock) on_pin <= 1'b1;
    see(`MSTA_ST_STANDBY);
    @(posedge clock) on_en <= 1'b1;
    see(`MSTA_ST_ACTIVE);
    chk(msk, `MSTA_MASK_ACTIVE);
    @(posedge clock) on_pin <= 1'b0;
    on_en <= 1'b0;
  endtask
  task t_warm(input logic [6:0] home, input logic [4:0] id);
    @(posedge clock) wd <= id == 5'h04;
    esm <= id == 5'h08;
    see(`MSTA_ST_WARM);
    chk(tid, id);
    chk(wrq, 1'b1);
    @(posedge clock) wd <= 1'b0;
    esm <= 1'b0;
    wrm_done <= 1'b1;
    @(posedge clock) wrm_done <= 1'b0;
    #1 chk(st, home);
    chk(wrq, 1'b0);
  endtask
  task t_sleep;
    u_host.sleep(1'b0, 1'b1);
    see(`MSTA_ST_MCU);
    chk(msk, `MSTA_MASK_MCU);
    t_warm(`MSTA_ST_MCU, 5'h08);
    u_host.wr(8'h00, 8'h01);
    see(`MSTA_ST_ACTIVE);
    u_host.sleep(1'b0, 1'b0);
    see(`MSTA_ST_S2R);
    chk(msk, `MSTA_MASK_S2R);
    u_host.sleep(1'b0, 1'b1);
    see(`MSTA_ST_ACTIVE);
  endtask
  // ids 10 and 11 pend together; the lower one is served first
  task t_bits;
    chk(crc, 1'b0);
    u_host.wr(8'h01, 8'h06);
    see(`MSTA_ST_ACTIVE);
    chk(scs, 1'b1);
    chk(tid, 5'h0A);
    see(`MSTA_ST_ACTIVE);
    chk(scs, 1'b0);
    chk(crc, 1'b1);
    chk(tid, 5'h0B);
  endtask
  // sleep lines at 11 hold id 14 high; the off request must still win
  task t_sw;
    u_host.wr(8'h01, 8'h01);
    see(`MSTA_ST_STANDBY);
    chk(tid, 5'h13);
    chk(tk, 1'b1);
    u_host.rd(8'h01, rdat);
    chk(rdat, 8'h00);
    u_host.rd(8'h02, rdat);
    chk(rdat, 8'h01);
    u_host.rd(8'h03, rdat);
    chk(rdat, 8'h13);
    u_host.rd(8'h00, rdat);
    chk(rdat, 8'h01);
    u_host.rd(8'h7F, rdat);
    chk(rdat, 8'h00);
    t_start;
    u_host.wr(8'h00, 8'h05);
    u_host.wr(8'h01, 8'h01);
    see(`MSTA_ST_LPSTBY);
    chk(msk, `MSTA_MASK_STANDBY);
  endtask
  // on request out of low-power standby towards mcu-only
  task t_wake;
    u_host.wr(8'h00, 8'h00);
    u_host.sleep(1'b0, 1'b1);
    @(posedge clock) dest <= 2'h2;
    on_pin <= 1'b1;
    on_en <= 1'b1;
    see(`MSTA_ST_MCU);
    chk(msk, `MSTA_MASK_MCU);
    @(posedge clock) on_pin <= 1'b0;
    on_en <= 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    see(`MSTA_ST_STANDBY);
    chk(msk, `MSTA_MASK_STANDBY);
    t_shutdown;
    t_start;
    t_warm(`MSTA_ST_ACTIVE, 5'h04);
    t_sleep;
    t_bits;
    t_sw;
    t_wake;
    give_verdict;
  end
  // whole run is under a hundred cycles
  initial begin
    repeat (3000) @(posedge clock);
    err_total++;
    give_verdict;
  end
endmodule // msta_arbiter_test
`default_nettype wire
